/* File: common/usp_regs.svh */
`ifndef USP_REGS_SVH
`define USP_REGS_SVH

// timing figures in ns, cycles derived in the top
`define USP_CLK_NS      25
`define USP_DEGLITCH_NS 1000
`define USP_BLANK_NS    100000
`define USP_PRST_NS     10000

// charge role codes
`define USP_ROLE_SDP    2'h0
`define USP_ROLE_CDP    2'h1
`define USP_ROLE_DCP_HI 2'h2
`define USP_ROLE_DCP_LO 2'h3

// strap step field positions
`define USP_S1_NO_SS    3
`define USP_S1_SYNC_OUT 2
`define USP_S3_HOLD     3
`define USP_S3_GAIN4    2

// reset values
`define USP_ERR_RST     8'h00
`define USP_STRAP_RST   4'h0

`endif

/* File: common/usp_pkg.sv */
`default_nettype none
package usp_pkg;

  // data switch mode
  typedef enum logic [2:0] {
    usp_mode_off     = 3'h0,
    usp_mode_invalid = 3'h1,
    usp_mode_sdp     = 3'h2,
    usp_mode_cdp     = 3'h3,
    usp_mode_dcp_hi  = 3'h4,
    usp_mode_dcp_lo  = 3'h5
  } usp_mode_t;

  // part variant, fixed per build
  typedef enum logic [2:0] {
    usp_var_sa_port_role_select = 3'h0,
    usp_var_sa_sdp_cdp = 3'h1,
    usp_var_sa_sdp_dcp = 3'h2,
    usp_var_i2c_cdp    = 3'h3,
    usp_var_i2c_sdp    = 3'h4
  } usp_variant_t;

  // role class for port-reset detection
  typedef enum logic [1:0] {
    usp_cls_none = 2'h0,
    usp_cls_comm = 2'h1,
    usp_cls_chg  = 2'h2
  } usp_cls_t;

  // port reset sequencer
  typedef enum logic {
    usp_prst_idle = 1'h0,
    usp_prst_busy = 1'h1
  } usp_prst_t;

endpackage
`default_nettype wire

/* File: rtl/usp_fault_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module usp_fault_filter #(
  parameter int W   = 16,
  parameter int DGL = 40,
  parameter int BLK = 4000
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] raw,
  input  wire logic         blank_start,
  output logic      [W-1:0] filt
);
  localparam int DW = $clog2(DGL + 1);
  localparam int BW = $clog2(BLK + 1);

  logic [W-1:0]  stable;   // deglitched copy of raw
  logic [BW-1:0] blk_cnt;  // blanking time left
  wire           blanking = (blk_cnt != '0);

  // per source deglitch: raw must differ for DGL cycles to flip
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_dgl
      logic [DW-1:0] cnt;
      wire           diff = raw[g] ^ stable[g];
      wire           done = (cnt == DW'(DGL - 1));
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt       <= '0;
          stable[g] <= 1'b0;
        end else if (!diff) begin
          cnt <= '0;
        end else if (done) begin
          cnt       <= '0;
          stable[g] <= raw[g];
        end else begin
          cnt <= cnt + DW'(1);
        end
      end
    end
  endgenerate

  // blanking timer restarts at startup; hides inrush faults
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      blk_cnt <= '0;
      filt    <= '0;
    end else begin
      if (blank_start) begin
        blk_cnt <= BW'(BLK);
      end else if (blanking) begin
        blk_cnt <= blk_cnt - BW'(1);
      end
      filt <= (blanking || blank_start) ? '0 : stable;
    end
  end

  property p_blank;
    @(posedge ref_clk) disable iff (!arst_n)
      blank_start |=> (filt == '0) [*8];
  endproperty
  a_blank: assert property (p_blank)
    else $error("fault seen during blanking");

endmodule
`default_nettype wire

/* File: rtl/usp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usp_regs.svh"
module usp_ctrl #(
  parameter usp_pkg::usp_variant_t VARIANT = usp_pkg::usp_var_sa_port_role_select,
  parameter int DGL_CYC  =
    (`USP_DEGLITCH_NS + `USP_CLK_NS - 1) / `USP_CLK_NS,
  parameter int BLK_CYC  =
    (`USP_BLANK_NS + `USP_CLK_NS - 1) / `USP_CLK_NS,
  parameter int PRST_CYC =
    (`USP_PRST_NS + `USP_CLK_NS - 1) / `USP_CLK_NS
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         high_voltage_enable,
  input  wire logic         supply_sense,
  input  wire logic         port_role_select,
  input  wire logic         cdp_detect_active,
  input  wire logic         device_attached,
  input  wire logic [3:0]   strap_resistor_one,
  input  wire logic [3:0]   strap_resistor_two,
  input  wire logic [3:0]   strap_resistor_three,
  input  wire logic [15:0]  fault_raw,
  input  wire logic         cfg_wr,
  input  wire logic         cfg_wr_ss_en,
  input  wire logic         cfg_wr_sync_dir,
  input  wire logic         role_wr,
  input  wire logic [1:0]   role_wr_code,
  input  wire logic         err_rd_a,
  input  wire logic         err_rd_b,
  input  wire logic [7:0]   alert_mask_reg_a,
  input  wire logic [7:0]   alert_mask_reg_b,
  output logic              direct_path_switch,
  output logic              charger_path_switch,
  output usp_pkg::usp_mode_t switch_mode,
  output logic              port_reset,
  output logic [1:0]        charge_role_code,
  output logic              ss_en,
  output logic              sync_dir,
  output logic [1:0]        i2c_addr_lsb,
  output logic [1:0]        osc_freq_code,
  output logic [4:0]        cable_gain,
  output logic [1:0]        usb_current_limit,
  output logic              hold_mode_en,
  output logic              i2c_enable,
  output logic [7:0]        err_cause_a,
  output logic [7:0]        err_cause_b,
  output logic              fault_n_o,
  output logic              fault_n_oe,
  output logic              attach_n_o,
  output logic              attach_n_oe
);

  // variant class, constant per build
  localparam logic IS_SA = (VARIANT == usp_pkg::usp_var_sa_port_role_select) ||
                           (VARIANT == usp_pkg::usp_var_sa_sdp_cdp) ||
                           (VARIANT == usp_pkg::usp_var_sa_sdp_dcp);
  localparam logic [1:0] ROLE_DEF =
    (VARIANT == usp_pkg::usp_var_i2c_cdp) ? `USP_ROLE_CDP
                                          : `USP_ROLE_SDP;

  // mode decode from pins, variant and role code
  function automatic usp_pkg::usp_mode_t f_mode(
    input logic       en,
    input logic       sup,
    input logic       role,
    input logic [1:0] code
  );
    f_mode = usp_pkg::usp_mode_off;
    if (!en) begin
      f_mode = usp_pkg::usp_mode_off;
    end else if (IS_SA) begin
      if (VARIANT == usp_pkg::usp_var_sa_port_role_select && role) begin
        f_mode = usp_pkg::usp_mode_dcp_hi;
      end else if (!sup) begin
        f_mode = usp_pkg::usp_mode_invalid;
      end else if (VARIANT == usp_pkg::usp_var_sa_port_role_select) begin
        f_mode = usp_pkg::usp_mode_cdp;
      end else if (VARIANT == usp_pkg::usp_var_sa_sdp_cdp) begin
        f_mode = role ? usp_pkg::usp_mode_cdp
                      : usp_pkg::usp_mode_sdp;
      end else begin
        f_mode = role ? usp_pkg::usp_mode_dcp_hi
                      : usp_pkg::usp_mode_sdp;
      end
    end else if (!sup) begin
      f_mode = usp_pkg::usp_mode_off;
    end else if (role) begin
      f_mode = usp_pkg::usp_mode_invalid;
    end else begin
      case (code)
        `USP_ROLE_SDP:    f_mode = usp_pkg::usp_mode_sdp;
        `USP_ROLE_CDP:    f_mode = usp_pkg::usp_mode_cdp;
        `USP_ROLE_DCP_HI: f_mode = usp_pkg::usp_mode_dcp_hi;
        default:          f_mode = usp_pkg::usp_mode_dcp_lo;
      endcase
    end
  endfunction

  // role class: communication, charging or none
  function automatic usp_pkg::usp_cls_t f_cls(
    input usp_pkg::usp_mode_t m
  );
    f_cls = usp_pkg::usp_cls_none;
    if (m == usp_pkg::usp_mode_sdp || m == usp_pkg::usp_mode_cdp) begin
      f_cls = usp_pkg::usp_cls_comm;
    end else if (m == usp_pkg::usp_mode_dcp_hi ||
                 m == usp_pkg::usp_mode_dcp_lo) begin
      f_cls = usp_pkg::usp_cls_chg;
    end
  endfunction

  // pin synchronisers: meta stage is read by the sync stage only
  localparam int PW = 17;
  logic [PW-1:0] pin_meta;   // first stage
  logic [PW-1:0] pin_sync;   // second stage
  logic [15:0]   flt_meta;   // fault first stage
  logic [15:0]   flt_sync;   // fault second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      flt_meta <= '0;
      flt_sync <= '0;
    end else begin
      pin_meta <= {high_voltage_enable, supply_sense, port_role_select,
                   cdp_detect_active, device_attached,
                   strap_resistor_one, strap_resistor_two,
                   strap_resistor_three};
      pin_sync <= pin_meta;
      flt_meta <= fault_raw;
      flt_sync <= flt_meta;
    end
  end

  // named views of the synchronised pins
  wire       en_s   = pin_sync[16];
  wire       sup_s  = pin_sync[15];
  wire       role_s = pin_sync[14];
  wire       cdp_s  = pin_sync[13];
  wire       att_s  = pin_sync[12];
  wire [3:0] s1     = pin_sync[11:8];
  wire [3:0] s2     = pin_sync[7:4];
  wire [3:0] s3     = pin_sync[3:0];

  // enable edge marks the leave-shutdown moment
  logic en_d;
  wire  en_rise = en_s & ~en_d;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_d <= 1'b0;
    end else begin
      en_d <= en_s;
    end
  end

  // i2c pins only carry a bus on bus variants
  assign i2c_enable = ~IS_SA;

  // software writes only on bus variants; startup load wins a tie
  wire sw_cfg  = cfg_wr  & ~IS_SA & ~en_rise;
  wire sw_role = role_wr & ~IS_SA & ~en_rise;

  // strap capture at startup; straps are static so a late sample
  // after the synchroniser is as good as the raw level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ss_en             <= 1'b0;
      sync_dir          <= 1'b0;
      i2c_addr_lsb      <= 2'h0;
      osc_freq_code     <= 2'h0;
      cable_gain        <= 5'h00;
      usb_current_limit <= 2'h0;
      hold_mode_en      <= 1'b0;
      charge_role_code  <= `USP_ROLE_SDP;
    end else if (en_rise) begin
      ss_en    <= ~s1[`USP_S1_NO_SS];
      sync_dir <= s1[`USP_S1_SYNC_OUT];
      if (IS_SA) begin
        osc_freq_code     <= s1[1:0];
        cable_gain        <= {s3[`USP_S3_GAIN4], s2};
        usb_current_limit <= s3[1:0];
        hold_mode_en      <= s3[`USP_S3_HOLD] &
          (VARIANT != usp_pkg::usp_var_sa_sdp_cdp);
      end else begin
        i2c_addr_lsb     <= s1[1:0];
        charge_role_code <= ROLE_DEF;
      end
    end else begin
      if (sw_cfg) begin
        ss_en    <= cfg_wr_ss_en;
        sync_dir <= cfg_wr_sync_dir;
      end
      if (sw_role) begin
        charge_role_code <= role_wr_code;
      end
    end
  end

  // mode selection and port reset sequencing
  usp_pkg::usp_mode_t next_mode;
  usp_pkg::usp_prst_t prst_st;
  usp_pkg::usp_prst_t next_prst_st;
  logic [15:0]        prst_cnt;
  assign next_mode = f_mode(en_s, sup_s, role_s, charge_role_code);
  wire cls_swap = (f_cls(next_mode) != usp_pkg::usp_cls_none) &&
                  (f_cls(switch_mode) != usp_pkg::usp_cls_none) &&
                  (f_cls(next_mode) != f_cls(switch_mode));
  wire prst_done = (prst_cnt == 16'(PRST_CYC - 1));

  // sequencer: a swap mid-reset simply restarts the count
  always_comb begin
    next_prst_st = prst_st;
    case (prst_st)
      usp_pkg::usp_prst_idle: begin
        if (cls_swap) begin
          next_prst_st = usp_pkg::usp_prst_busy;
        end
      end
      default: begin
        if (prst_done && !cls_swap) begin
          next_prst_st = usp_pkg::usp_prst_idle;
        end
      end
    endcase
  end

  wire prst_next = (next_prst_st == usp_pkg::usp_prst_busy);

  // switch drive; an invalid bus variant parks on the charger path
  wire sw_dir_w = (switch_mode == usp_pkg::usp_mode_sdp) ||
                  (switch_mode == usp_pkg::usp_mode_cdp && !cdp_s);
  wire sw_chg_w = (f_cls(switch_mode) == usp_pkg::usp_cls_chg) ||
                  (switch_mode == usp_pkg::usp_mode_cdp && cdp_s) ||
                  (switch_mode == usp_pkg::usp_mode_invalid && !IS_SA);

  // mode, sequencer and switch registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_mode         <= usp_pkg::usp_mode_off;
      prst_st             <= usp_pkg::usp_prst_idle;
      prst_cnt            <= 16'h0000;
      direct_path_switch  <= 1'b0;
      charger_path_switch <= 1'b0;
    end else begin
      switch_mode <= next_mode;
      prst_st     <= next_prst_st;
      prst_cnt    <= (prst_st == usp_pkg::usp_prst_busy && !cls_swap &&
                      !prst_done) ? prst_cnt + 16'h0001 : 16'h0000;
      // both paths open while the port is being reset
      direct_path_switch  <= sw_dir_w & ~prst_next;
      charger_path_switch <= sw_chg_w & ~prst_next;
    end
  end
  assign port_reset = (prst_st == usp_pkg::usp_prst_busy);

  // fault filtering
  logic [15:0] flt;     // filtered fault conditions
  logic [15:0] flt_d;   // previous filtered value
  usp_fault_filter #(
    .W   (16),
    .DGL (DGL_CYC),
    .BLK (BLK_CYC)
  ) u_filter (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .raw         (flt_sync),
    .blank_start (en_rise),
    .filt        (flt)
  );
  wire [15:0] flt_rise = flt & ~flt_d;
  wire        flt_any  = |flt;

  // cause bits: read clears after the data was taken; a new onset
  // in the read cycle survives, a standing fault returns a cycle on
  wire [7:0] next_err_a = err_rd_a ? flt_rise[7:0]
                                   : (err_cause_a | flt[7:0]);
  wire [7:0] next_err_b = err_rd_b ? flt_rise[15:8]
                                   : (err_cause_b | flt[15:8]);
  wire int_req = |(err_cause_a & alert_mask_reg_a) |
                 |(err_cause_b & alert_mask_reg_b);
  wire att_drv = IS_SA ? att_s : int_req;

  // cause registers and open-drain pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flt_d       <= 16'h0000;
      err_cause_a <= `USP_ERR_RST;
      err_cause_b <= `USP_ERR_RST;
      fault_n_oe  <= 1'b1;
      attach_n_oe <= 1'b1;
    end else begin
      flt_d       <= flt;
      err_cause_a <= next_err_a;
      err_cause_b <= next_err_b;
      fault_n_oe  <= ~flt_any;
      attach_n_oe <= ~att_drv;
    end
  end
  assign fault_n_o  = 1'b0;
  assign attach_n_o = 1'b0;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_off;
    IS_SA && !en_s |=> switch_mode == usp_pkg::usp_mode_off;
  endproperty
  a_off: assert property (p_off)
    else $error("mode not off with enable low");

  property p_invalid;
    IS_SA && en_s && !sup_s && !role_s
      |=> switch_mode == usp_pkg::usp_mode_invalid ##1
          !direct_path_switch && !charger_path_switch;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid state closed a switch");

  property p_dcp;
    VARIANT == usp_pkg::usp_var_sa_port_role_select && en_s && role_s
      |=> switch_mode == usp_pkg::usp_mode_dcp_hi;
  endproperty
  a_dcp: assert property (p_dcp)
    else $error("role high did not give charging mode");

  property p_cdp_sw;
    switch_mode == usp_pkg::usp_mode_cdp && cdp_s && !prst_next
      |=> charger_path_switch && !direct_path_switch;
  endproperty
  a_cdp_sw: assert property (p_cdp_sw)
    else $error("cdp detection switch wrong");

  property p_role_lo;
    !IS_SA && en_s && sup_s && !role_s &&
      charge_role_code == `USP_ROLE_DCP_LO
      |=> switch_mode == usp_pkg::usp_mode_dcp_lo;
  endproperty
  a_role_lo: assert property (p_role_lo)
    else $error("role code 3 not low charging");

  property p_strap;
    en_rise |=> ss_en == !$past(s1[`USP_S1_NO_SS]) &&
                sync_dir == $past(s1[`USP_S1_SYNC_OUT]);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap one not loaded at startup");

  property p_hold;
    VARIANT == usp_pkg::usp_var_sa_sdp_cdp |-> !hold_mode_en;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold mode on for sdp/cdp part");

  property p_fault;
    ##1 fault_n_oe == !$past(flt_any);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault pin does not track faults");

  property p_clear;
    err_rd_a |=> err_cause_a == $past(flt_rise[7:0]);
  endproperty
  a_clear: assert property (p_clear)
    else $error("cause a not cleared by read");

  property p_mask;
    !IS_SA && (err_cause_a & alert_mask_reg_a) == 8'h00 &&
      (err_cause_b & alert_mask_reg_b) == 8'h00 |=> attach_n_oe;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt for masked source");

  property p_prst;
    $rose(port_reset) |-> (port_reset && !direct_path_switch &&
                           !charger_path_switch) [*8];
  endproperty
  a_prst: assert property (p_prst)
    else $error("port reset short or switch closed");

  c_cdp:   cover property (switch_mode == usp_pkg::usp_mode_cdp && cdp_s);
  c_prst:  cover property ($fell(port_reset));
  c_int:   cover property (!IS_SA && $fell(attach_n_oe));
  c_reset: cover property (err_rd_a && flt[0] ##2 err_cause_a[0]);

endmodule
`default_nettype wire

/* File: test/usp_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: attached device, charge detector and the pull-ups on both pins
module usp_partner (
  input  wire logic fault_n_o,
  input  wire logic fault_n_oe,
  input  wire logic attach_n_o,
  input  wire logic attach_n_oe,
  input  wire logic attach_cmd,
  input  wire logic detect_cmd,
  output logic      device_attached,
  output logic      cdp_detect_active,
  output logic      fault_wire,
  output logic      attach_wire
);
  // levels that the bench commands, passed on unchanged
  assign device_attached   = attach_cmd;
  assign cdp_detect_active = detect_cmd;
  // pull-up wins while released; a driven pin shows its low level
  assign fault_wire  = fault_n_oe ? 1'b1 : fault_n_o;
  assign attach_wire = attach_n_oe ? 1'b1 : attach_n_o;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// compare a design value with its expected value, count both outcomes
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
  // one row: pin levels beside the mode and switches they should give
  typedef struct packed {
    logic en, sup, role, det;
    usp_pkg::usp_mode_t m;
    logic da, ch;
  } usp_row_t;
  logic ref_clk, arst_n, high_voltage_enable, supply_sense, port_role_select;
  logic cdp_detect_active, device_attached, cfg_wr, cfg_wr_ss_en;
  logic cfg_wr_sync_dir, role_wr, err_rd_a, err_rd_b, attach_cmd, detect_cmd;
  logic [3:0] strap_resistor_one, strap_resistor_two, strap_resistor_three;
  logic [15:0] fault_raw;
  logic [1:0] role_wr_code, charge_role_code, i2c_addr_lsb, osc_freq_code;
  logic [1:0] usb_current_limit;
  logic [7:0] alert_mask_reg_a, alert_mask_reg_b, err_cause_a, err_cause_b;
  logic direct_path_switch, charger_path_switch, port_reset, ss_en, sync_dir;
  logic hold_mode_en, i2c_enable, fault_n_o, fault_n_oe, attach_n_o;
  logic attach_n_oe, fault_wire, attach_wire;
  logic [4:0] cable_gain;
  usp_pkg::usp_mode_t switch_mode;
  int n_mismatch, comparisons;
  usp_row_t rows [6];
  // bus-variant copy shares every input; only its checked outputs are kept
  usp_pkg::usp_mode_t b_mode;
  logic [1:0] b_role, b_addr;
  logic b_dir, b_chg, b_ss, b_sync, b_i2c, b_att_oe;
  logic [7:0] b_err_a;
  wire [1:0] sw_pair = {direct_path_switch, charger_path_switch};
  wire [4:0] b_state = {b_mode, b_dir, b_chg};
  // short counts keep the run brief; expectations use the same values
  usp_ctrl #(.VARIANT(usp_pkg::usp_var_sa_port_role_select), .DGL_CYC(2),
    .BLK_CYC(8), .PRST_CYC(8)) DUT (
    .ref_clk, .arst_n, .high_voltage_enable, .supply_sense,
    .port_role_select, .cdp_detect_active, .device_attached,
    .strap_resistor_one, .strap_resistor_two, .strap_resistor_three,
    .fault_raw, .cfg_wr, .cfg_wr_ss_en, .cfg_wr_sync_dir, .role_wr,
    .role_wr_code, .err_rd_a, .err_rd_b, .alert_mask_reg_a,
    .alert_mask_reg_b, .direct_path_switch, .charger_path_switch,
    .switch_mode, .port_reset, .charge_role_code, .ss_en, .sync_dir,
    .i2c_addr_lsb, .osc_freq_code, .cable_gain, .usb_current_limit,
    .hold_mode_en, .i2c_enable, .err_cause_a, .err_cause_b, .fault_n_o,
    .fault_n_oe, .attach_n_o, .attach_n_oe);
  usp_partner u_partner (.fault_n_o, .fault_n_oe, .attach_n_o,
    .attach_n_oe, .attach_cmd, .detect_cmd, .device_attached,
    .cdp_detect_active, .fault_wire, .attach_wire);
  // bus part with cdp default, so role codes, writes and masks get used
  usp_ctrl #(.VARIANT(usp_pkg::usp_var_i2c_cdp), .DGL_CYC(2),
    .BLK_CYC(8), .PRST_CYC(8)) DUT_BUS (
    .ref_clk, .arst_n, .high_voltage_enable, .supply_sense,
    .port_role_select, .cdp_detect_active, .device_attached,
    .strap_resistor_one, .strap_resistor_two, .strap_resistor_three,
    .fault_raw, .cfg_wr, .cfg_wr_ss_en, .cfg_wr_sync_dir, .role_wr,
    .role_wr_code, .err_rd_a, .err_rd_b, .alert_mask_reg_a,
    .alert_mask_reg_b, .direct_path_switch(b_dir),
    .charger_path_switch(b_chg), .switch_mode(b_mode), .port_reset(),
    .charge_role_code(b_role), .ss_en(b_ss), .sync_dir(b_sync),
    .i2c_addr_lsb(b_addr), .osc_freq_code(), .cable_gain(),
    .usb_current_limit(), .hold_mode_en(), .i2c_enable(b_i2c),
    .err_cause_a(b_err_a), .err_cause_b(), .fault_n_o(), .fault_n_oe(),
    .attach_n_o(), .attach_n_oe(b_att_oe));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // wait n edges, then step off the edge so drives and samples are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // verdict and end of run, the only place that stops
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial begin
    {arst_n, high_voltage_enable, supply_sense, port_role_select} = 4'h0;
    {cfg_wr, cfg_wr_ss_en, cfg_wr_sync_dir, role_wr} = 4'h0;
    {err_rd_a, err_rd_b, attach_cmd, detect_cmd} = 4'h0;
    role_wr_code = 2'h0;
    alert_mask_reg_a = 8'hFF;
    alert_mask_reg_b = 8'hFF;
    fault_raw = 16'h0000;
    strap_resistor_one = 4'hB;   // no spread, sync in, freq code 3
    strap_resistor_two = 4'h5;   // gain low bits
    strap_resistor_three = 4'hE; // hold on, gain top 1, limit code 2
    n_mismatch = 0;
    comparisons = 0;
    // port_role_select part: enable low overrides a high role pin and supply
    rows[0] = {4'b0111, usp_pkg::usp_mode_off, 2'b00};
    rows[1] = {4'b1000, usp_pkg::usp_mode_invalid, 2'b00};
    rows[2] = {4'b1100, usp_pkg::usp_mode_cdp, 2'b10};
    rows[3] = {4'b1101, usp_pkg::usp_mode_cdp, 2'b01};
    rows[4] = {4'b1010, usp_pkg::usp_mode_dcp_hi, 2'b01};
    rows[5] = {4'b1110, usp_pkg::usp_mode_dcp_hi, 2'b01};
    cyc(6);
    `CHK(switch_mode, usp_pkg::usp_mode_off)
    `CHK(fault_n_oe, 1'b1)
    `CHK(attach_n_oe, 1'b1)
    arst_n = 1'b1;
    cyc(2);
    // table rows; 25 cycles outlast sync, port reset and blanking
    for (int i = 0; i < 6; i++) begin
      {high_voltage_enable, supply_sense, port_role_select, detect_cmd} =
        {rows[i].en, rows[i].sup, rows[i].role, rows[i].det};
      cyc(25);
      `CHK(switch_mode, rows[i].m)
      `CHK(sw_pair, {rows[i].da, rows[i].ch})
    end
    // straps loaded at the enable rise of row 1
    `CHK({ss_en, sync_dir, osc_freq_code}, 4'h3)
    `CHK(cable_gain, 5'h15)
    `CHK({usb_current_limit, hold_mode_en}, 3'h5)
    `CHK({i2c_enable, i2c_addr_lsb}, 3'h0)
    // bus part at row 5: role pin high is invalid, charger path closed
    `CHK(b_state, {usp_pkg::usp_mode_invalid, 2'b01})
    `CHK(b_role, 2'h1)
    `CHK({b_addr, b_ss, b_sync, b_i2c}, 5'h19)
    // bus writes refused on a stand-alone part, taken on the bus part
    {cfg_wr, cfg_wr_ss_en, role_wr, role_wr_code} = 5'h1E;
    cyc(1);
    {cfg_wr, role_wr} = 2'h0;
    cyc(2);
    `CHK(ss_en, 1'b0)
    `CHK(charge_role_code, 2'h0)
    `CHK({b_ss, b_role}, 3'h6)
    // charging back to communication: switches open during port reset
    port_role_select = 1'b0;
    cyc(5);
    `CHK({port_reset, sw_pair}, 3'h4)
    cyc(20);
    `CHK({port_reset, direct_path_switch}, 2'h1)
    `CHK(b_mode, usp_pkg::usp_mode_dcp_hi)
    // bus part: role code 3 gives low charging, code 0 a port reset
    {role_wr, role_wr_code} = 3'h7;
    cyc(1);
    role_wr = 1'b0;
    cyc(3);
    `CHK(b_mode, usp_pkg::usp_mode_dcp_lo)
    {role_wr, role_wr_code} = 3'h4;
    cyc(1);
    role_wr = 1'b0;
    cyc(3);
    `CHK(b_state, {usp_pkg::usp_mode_sdp, 2'b00})
    cyc(12);
    `CHK({b_dir, b_chg}, 2'b10)
    // one-cycle glitch must not reach the fault pin
    fault_raw = 16'h0002;
    cyc(1);
    fault_raw = 16'h0000;
    cyc(10);
    `CHK(fault_wire, 1'b1)
    // standing fault holds the pin and its cause bit
    fault_raw = 16'h0004;
    cyc(10);
    `CHK(fault_wire, 1'b0)
    `CHK(err_cause_a, 8'h04)
    `CHK(b_att_oe, 1'b0)
    err_rd_a = 1'b1;
    cyc(1);
    err_rd_a = 1'b0;
    `CHK(err_cause_a, 8'h00)
    cyc(1);
    `CHK(err_cause_a, 8'h04)
    `CHK(fault_wire, 1'b0)
    `CHK(b_att_oe, 1'b1)
    cyc(1);
    `CHK(b_att_oe, 1'b0)
    // fault gone: read clears for good and the pin is released
    fault_raw = 16'h0000;
    cyc(10);
    `CHK(fault_wire, 1'b1)
    {err_rd_a, err_rd_b} = 2'h3;
    cyc(1);
    {err_rd_a, err_rd_b} = 2'h0;
    cyc(2);
    `CHK({err_cause_a, err_cause_b}, 16'h0000)
    // masked source: cause bit set, interrupt pin stays released
    alert_mask_reg_a = 8'hFB;
    fault_raw = 16'h0004;
    cyc(10);
    `CHK({b_err_a, b_att_oe}, 9'h009)
    fault_raw = 16'h0000;
    // attach indication on the shared pin
    attach_cmd = 1'b1;
    cyc(5);
    `CHK(attach_wire, 1'b0)
    attach_cmd = 1'b0;
    cyc(5);
    `CHK(attach_wire, 1'b1)
    test_done();
  end
endmodule
`default_nettype wire
